// [design/itd_defines.vh]
`ifndef ITD_DEFINES_VH
`define ITD_DEFINES_VH

// Instruction word and operand widths.
`define ITD_WORD_W        24
`define ITD_OPC_MSB       23
`define ITD_OPC_LSB       18
`define ITD_BASE_OPS      84
`define ITD_ADD_VARIANTS  6
`define ITD_DIV_REPEATS   18

// Functional groups.
`define ITD_GRP_MOVE      4'h0
`define ITD_GRP_MATH      4'h1
`define ITD_GRP_LOGIC     4'h2
`define ITD_GRP_SHIFT     4'h3
`define ITD_GRP_BIT       4'h4
`define ITD_GRP_SKIP      4'h5
`define ITD_GRP_FLOW      4'h6
`define ITD_GRP_STACK     4'h7
`define ITD_GRP_CTRL      4'h8
`define ITD_GRP_DSP       4'h9
`define ITD_GRP_NONE      4'hF

// Operation classes carried in opcode bits 23:18 (decoder encoding).
`define ITD_OP_MOVE       6'h00
`define ITD_OP_XFER_DW    6'h01
`define ITD_OP_TBL_RDH    6'h02
`define ITD_OP_TBL_RDL    6'h03
`define ITD_OP_TBL_WTH    6'h04
`define ITD_OP_TBL_WTL    6'h05
`define ITD_OP_ADD_F      6'h06
`define ITD_OP_ADD_L10    6'h07
`define ITD_OP_ADD_L5     6'h08
`define ITD_OP_ADD_WW     6'h09
`define ITD_OP_ADD_B_L10  6'h0A
`define ITD_OP_ADD_B_WW   6'h0B
`define ITD_OP_MATH       6'h0C
`define ITD_OP_DIV_S      6'h0D
`define ITD_OP_DIV_U      6'h0E
`define ITD_OP_DIV_F      6'h0F
`define ITD_OP_MUL        6'h10
`define ITD_OP_LOGIC      6'h11
`define ITD_OP_SHIFT      6'h12
`define ITD_OP_BIT        6'h13
`define ITD_OP_SKIP       6'h14
`define ITD_OP_BRANCH     6'h15
`define ITD_OP_CALL       6'h16
`define ITD_OP_GOTO       6'h17
`define ITD_OP_LOOP       6'h18
`define ITD_OP_RETURN     6'h19
`define ITD_OP_RET_INT    6'h1A
`define ITD_OP_RET_LIT    6'h1B
`define ITD_OP_PUSH_DW    6'h1C
`define ITD_OP_POP_DW     6'h1D
`define ITD_OP_STACK      6'h1E
`define ITD_OP_CTRL       6'h1F
`define ITD_OP_DSP        6'h20
`define ITD_OP_REPEAT     6'h21

// Cycle and word counts.
`define ITD_CYC_ONE       2'h1
`define ITD_CYC_TWO       2'h2
`define ITD_CYC_THREE     2'h3
`define ITD_WORDS_ONE     2'h1
`define ITD_WORDS_TWO     2'h2
`define ITD_CNT_ZERO      2'h0
`define ITD_DIV_CNT_W     5
`define ITD_DIV_LAST      5'h11
`define ITD_DIV_ZERO      5'h00

// Operand field positions.
`define ITD_B4_LSB        12
`define ITD_L1_LSB        14
`define ITD_L4_LSB        4
`define ITD_L5_LSB        4
`define ITD_L8_LSB        4
`define ITD_L10_LSB       4
`define ITD_L14_LSB       0
`define ITD_L16_LSB       0
`define ITD_L23_LSB       0
`define ITD_WD_LSB        7
`define ITD_WS_LSB        0
`define ITD_IND_BIT       11
`define ITD_BYTE_BIT      14
`define ITD_ACC_BIT       15
`define ITD_AWB_BIT       16
`define ITD_XS_LSB        12
`define ITD_YS_LSB        8
`define ITD_XD_LSB        6
`define ITD_YD_LSB        4
`define ITD_SQR_BIT       17
`define ITD_BYTE_MAX      10'h0FF

`endif

// [design/itd_field_extract.v]
`timescale 1ns/1ps
`include "itd_defines.vh"

module itd_field_extract (
  // Instruction word and byte mode.
  input  wire [23:0] instrWord,
  input  wire        byteMode,
  // Unsigned literals.
  output wire        lit1,
  output wire [3:0]  lit4,
  output wire [4:0]  lit5,
  output wire [7:0]  lit8,
  output wire [9:0]  tenBitLiteral,
  output wire [13:0] lit14,
  output wire [15:0] lit16,
  output wire [22:0] lit23,
  // Signed literals, sign extended to 16 bits.
  output wire [15:0] slit4,
  output wire [15:0] signedTenBitLiteral,
  output wire [15:0] slit16,
  // Bit position.
  output wire [3:0]  bitPositionField
);

  wire [9:0] rawLit10;

  assign lit1   = instrWord[`ITD_L1_LSB];
  assign lit4   = instrWord[`ITD_L4_LSB +: 4];
  assign lit5   = instrWord[`ITD_L5_LSB +: 5];
  assign lit8   = instrWord[`ITD_L8_LSB +: 8];
  assign lit14  = instrWord[`ITD_L14_LSB +: 14];
  assign lit16  = instrWord[`ITD_L16_LSB +: 16];
  assign lit23  = instrWord[`ITD_L23_LSB +: 23];
  assign rawLit10 = instrWord[`ITD_L10_LSB +: 10];
  // Byte mode masks the ten-bit literal to its low byte.
  assign tenBitLiteral = byteMode ? (rawLit10 & `ITD_BYTE_MAX) : rawLit10;
  assign slit4  = {{12{lit4[3]}}, lit4};
  assign signedTenBitLiteral = {{6{rawLit10[9]}}, rawLit10};
  assign slit16 = lit16;
  assign bitPositionField = instrWord[`ITD_B4_LSB +: 4];

endmodule

// [design/itd_instruction_timing_decoder.v]
`timescale 1ns/1ps
`include "itd_defines.vh"

module itd_instruction_timing_decoder (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Fetch side.
  input  wire        instrValid,
  input  wire [23:0] instrWord,
  input  wire        skipTaken,
  input  wire        nextIsTwoWord,
  input  wire        exceptionPending,
  input  wire        psvAccess,
  input  wire [1:0]  psvExtraCycles,
  input  wire        repeatActive,
  input  wire        interruptReq,
  // Pipeline handshake.
  output wire        decodeReady,
  output wire        fetchSecondWord,
  output wire        insertNop,
  // Decoded classification.
  output reg  [3:0]  funcGroup,
  output reg  [5:0]  opClass,
  output reg         opKnown,
  output reg  [1:0]  wordCount,
  output reg  [2:0]  cycleCount,
  output reg         isDivideStep,
  output reg         divideInterruptible,
  output reg  [4:0]  divideStepIndex,
  // Register operands.
  output reg  [3:0]  destWorkRegister,
  output reg  [3:0]  srcWorkRegister,
  output reg         srcIndirect,
  output reg         destIndirect,
  output reg  [3:0]  divideRegisterPair,
  output reg  [3:0]  divisorRegister,
  output reg         mulSquare,
  // Signal-processing operands.
  output reg         accSelect,
  output reg         accumulatorWriteBack,
  output reg  [3:0]  xPrefetchSource,
  output reg  [3:0]  yPrefetchSource,
  output reg  [1:0]  xPrefetchDest,
  output reg  [1:0]  yPrefetchDest,
  // Literal and bit fields.
  output reg  [9:0]  tenBitLiteralOut,
  output reg  [15:0] signedTenBitLiteralOut,
  output reg  [15:0] lit16Out,
  output reg  [22:0] lit23Out,
  output reg  [4:0]  lit5Out,
  output reg  [15:0] slit4Out,
  output reg  [3:0]  bitPositionFieldOut
);

  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [2:0] remain_ff;
  reg  [2:0] nxt_remain;
  reg        needSecond_ff;
  reg        nxt_needSecond;
  reg  [4:0] divCnt_ff;
  reg  [4:0] nxt_divCnt;

  wire [5:0]  opc;
  wire        byteMode;
  wire [4:0]  fLit5;
  wire [9:0]  fLit10;
  wire [22:0] fLit23;
  wire [15:0] fSlit4;
  wire [15:0] fSlit10;
  wire [15:0] fSlit16;
  wire [3:0]  fBit4;
  wire        take;
  reg  [3:0]  grp;
  reg         known;
  reg  [1:0]  words;
  reg  [2:0]  cycles;
  reg         isDiv;

  // Map an operation class to its functional group.
  function [3:0] groupOf;
    input [5:0] op;
    begin
      case (op)
        `ITD_OP_MOVE, `ITD_OP_XFER_DW, `ITD_OP_TBL_RDH, `ITD_OP_TBL_RDL,
        `ITD_OP_TBL_WTH, `ITD_OP_TBL_WTL: groupOf = `ITD_GRP_MOVE;
        `ITD_OP_ADD_F, `ITD_OP_ADD_L10, `ITD_OP_ADD_L5, `ITD_OP_ADD_WW,
        `ITD_OP_ADD_B_L10, `ITD_OP_ADD_B_WW, `ITD_OP_MATH, `ITD_OP_DIV_S,
        `ITD_OP_DIV_U, `ITD_OP_DIV_F, `ITD_OP_MUL: groupOf = `ITD_GRP_MATH;
        `ITD_OP_LOGIC: groupOf = `ITD_GRP_LOGIC;
        `ITD_OP_SHIFT: groupOf = `ITD_GRP_SHIFT;
        `ITD_OP_BIT: groupOf = `ITD_GRP_BIT;
        `ITD_OP_SKIP: groupOf = `ITD_GRP_SKIP;
        `ITD_OP_BRANCH, `ITD_OP_CALL, `ITD_OP_GOTO, `ITD_OP_LOOP,
        `ITD_OP_RETURN, `ITD_OP_RET_INT, `ITD_OP_RET_LIT,
        `ITD_OP_REPEAT: groupOf = `ITD_GRP_FLOW;
        `ITD_OP_PUSH_DW, `ITD_OP_POP_DW, `ITD_OP_STACK: groupOf = `ITD_GRP_STACK;
        `ITD_OP_CTRL: groupOf = `ITD_GRP_CTRL;
        `ITD_OP_DSP: groupOf = `ITD_GRP_DSP;
        default: groupOf = `ITD_GRP_NONE;
      endcase
    end
  endfunction

  assign opc      = instrWord[`ITD_OPC_MSB:`ITD_OPC_LSB];
  assign byteMode = instrWord[`ITD_BYTE_BIT];

  itd_field_extract uFields (
    .instrWord           (instrWord),
    .byteMode            (byteMode),
    .lit1                (),
    .lit4                (),
    .lit5                (fLit5),
    .lit8                (),
    .tenBitLiteral       (fLit10),
    .lit14               (),
    .lit16               (),
    .lit23               (fLit23),
    .slit4               (fSlit4),
    .signedTenBitLiteral (fSlit10),
    .slit16              (fSlit16),
    .bitPositionField    (fBit4)
  );

  // Word and cycle counts for the presented instruction.
  always @* begin
    grp    = groupOf(opc);
    known  = (grp != `ITD_GRP_NONE);
    words  = `ITD_WORDS_ONE;
    cycles = {1'b0, `ITD_CYC_ONE};
    isDiv  = 1'b0;
    case (opc)
      `ITD_OP_XFER_DW, `ITD_OP_TBL_RDH, `ITD_OP_TBL_RDL, `ITD_OP_TBL_WTH,
      `ITD_OP_TBL_WTL, `ITD_OP_PUSH_DW, `ITD_OP_POP_DW: begin
        cycles = {1'b0, `ITD_CYC_TWO};
      end
      `ITD_OP_LOOP: begin
        cycles = {1'b0, `ITD_CYC_TWO};
        words  = `ITD_WORDS_TWO;
      end
      `ITD_OP_CALL, `ITD_OP_GOTO: begin
        cycles = {1'b0, `ITD_CYC_TWO};
        words  = `ITD_WORDS_TWO;
      end
      `ITD_OP_BRANCH: begin
        cycles = {1'b0, `ITD_CYC_TWO};
      end
      `ITD_OP_SKIP: begin
        if (skipTaken) begin
          cycles = nextIsTwoWord ? {1'b0, `ITD_CYC_THREE} : {1'b0, `ITD_CYC_TWO};
        end
      end
      `ITD_OP_RETURN, `ITD_OP_RET_INT, `ITD_OP_RET_LIT: begin
        cycles = exceptionPending ? {1'b0, `ITD_CYC_TWO} : {1'b0, `ITD_CYC_THREE};
      end
      `ITD_OP_DIV_S, `ITD_OP_DIV_U, `ITD_OP_DIV_F: begin
        isDiv = 1'b1;
      end
      default: begin
        cycles = {1'b0, `ITD_CYC_ONE};
      end
    endcase
    if (psvAccess) begin
      cycles = cycles + {1'b0, psvExtraCycles};
    end
  end

  assign take            = instrValid && (state_ff == ST_IDLE);
  assign decodeReady     = (state_ff == ST_IDLE);
  assign insertNop       = (state_ff == ST_BUSY);
  assign fetchSecondWord = (state_ff == ST_BUSY) && needSecond_ff;

  // Sequencer holding the decoder while filler cycles run.
  always @* begin
    nxt_state      = state_ff;
    nxt_remain     = remain_ff;
    nxt_needSecond = needSecond_ff;
    nxt_divCnt     = divCnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_needSecond = (words == `ITD_WORDS_TWO);
          if (cycles > {1'b0, `ITD_CYC_ONE}) begin
            nxt_state  = ST_BUSY;
            nxt_remain = cycles - 3'h1;
          end
          if (isDiv && repeatActive) begin
            // Count repeated steps; the repeat itself is one more cycle.
            nxt_divCnt = (divCnt_ff == `ITD_DIV_LAST) ? `ITD_DIV_ZERO :
                         divCnt_ff + 5'h01;
          end else if (!repeatActive) begin
            nxt_divCnt = `ITD_DIV_ZERO;
          end
        end
      end
      ST_BUSY: begin
        nxt_needSecond = 1'b0;
        nxt_remain     = remain_ff - 3'h1;
        if (remain_ff == 3'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= ST_IDLE;
      remain_ff     <= 3'h0;
      needSecond_ff <= 1'b0;
      divCnt_ff     <= `ITD_DIV_ZERO;
    end else begin
      state_ff      <= nxt_state;
      remain_ff     <= nxt_remain;
      needSecond_ff <= nxt_needSecond;
      divCnt_ff     <= nxt_divCnt;
    end
  end

  // Registered decode results, captured when an instruction is taken.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      funcGroup              <= `ITD_GRP_NONE;
      opClass                <= 6'h00;
      opKnown                <= 1'b0;
      wordCount              <= `ITD_CNT_ZERO;
      cycleCount             <= 3'h0;
      isDivideStep           <= 1'b0;
      divideInterruptible    <= 1'b0;
      divideStepIndex        <= `ITD_DIV_ZERO;
      destWorkRegister       <= 4'h0;
      srcWorkRegister        <= 4'h0;
      srcIndirect            <= 1'b0;
      destIndirect           <= 1'b0;
      divideRegisterPair     <= 4'h0;
      divisorRegister        <= 4'h0;
      mulSquare              <= 1'b0;
      accSelect              <= 1'b0;
      accumulatorWriteBack   <= 1'b0;
      xPrefetchSource        <= 4'h0;
      yPrefetchSource        <= 4'h0;
      xPrefetchDest          <= 2'h0;
      yPrefetchDest          <= 2'h0;
      tenBitLiteralOut       <= 10'h000;
      signedTenBitLiteralOut <= 16'h0000;
      lit16Out               <= 16'h0000;
      lit23Out               <= 23'h000000;
      lit5Out                <= 5'h00;
      slit4Out               <= 16'h0000;
      bitPositionFieldOut    <= 4'h0;
    end else if (take) begin
      funcGroup           <= grp;
      opClass             <= opc;
      opKnown             <= known;
      wordCount           <= words;
      cycleCount          <= cycles;
      isDivideStep        <= isDiv;
      divideInterruptible <= isDiv && repeatActive && interruptReq;
      divideStepIndex     <= divCnt_ff;
      destWorkRegister    <= instrWord[`ITD_WD_LSB +: 4];
      srcWorkRegister     <= instrWord[`ITD_WS_LSB +: 4];
      // Restricted fields are direct only; indirect bit is honoured elsewhere.
      srcIndirect         <= instrWord[`ITD_IND_BIT] && !isDiv && (opc != `ITD_OP_MUL);
      destIndirect        <= instrWord[`ITD_IND_BIT] && (grp != `ITD_GRP_DSP);
      divideRegisterPair  <= instrWord[`ITD_WD_LSB +: 4];
      divisorRegister     <= instrWord[`ITD_WS_LSB +: 4];
      mulSquare           <= (opc == `ITD_OP_MUL) && instrWord[`ITD_SQR_BIT];
      accSelect           <= instrWord[`ITD_ACC_BIT];
      accumulatorWriteBack <= (grp == `ITD_GRP_DSP) && instrWord[`ITD_AWB_BIT];
      xPrefetchSource     <= instrWord[`ITD_XS_LSB +: 4];
      yPrefetchSource     <= instrWord[`ITD_YS_LSB +: 4];
      xPrefetchDest       <= instrWord[`ITD_XD_LSB +: 2];
      yPrefetchDest       <= instrWord[`ITD_YD_LSB +: 2];
      tenBitLiteralOut    <= fLit10;
      signedTenBitLiteralOut <= fSlit10;
      lit16Out            <= fSlit16;
      lit23Out            <= fLit23;
      lit5Out             <= fLit5;
      slit4Out            <= fSlit4;
      bitPositionFieldOut <= fBit4;
    end
  end

endmodule

// [testbench/itd_decoder_chk.sv]
`timescale 1ns/1ps
`include "itd_defines.vh"

module itd_decoder_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        nrst,
  // Decoder inputs.
  input wire logic        instrValid,
  input wire logic [23:0] instrWord,
  input wire logic        skipTaken,
  input wire logic        nextIsTwoWord,
  input wire logic        exceptionPending,
  input wire logic        psvAccess,
  input wire logic        repeatActive,
  input wire logic        interruptReq,
  // Decoder outputs.
  input wire logic        decodeReady,
  input wire logic        fetchSecondWord,
  input wire logic        insertNop,
  input wire logic [5:0]  opClass,
  input wire logic [1:0]  wordCount,
  input wire logic [2:0]  cycleCount,
  input wire logic        isDivideStep,
  input wire logic [9:0]  tenBitLiteralOut,
  input wire logic [3:0]  bitPositionFieldOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // A taken instruction without program-space overhead.
  wire       tk = instrValid && decodeReady && !psvAccess;
  wire [5:0] op = instrWord[23:18];
  wire       w2 = op == `ITD_OP_CALL || op == `ITD_OP_GOTO || op == `ITD_OP_LOOP;

  oneCycle_a: assert property (tk && op == `ITD_OP_MOVE |=> cycleCount == 3'h1
    && decodeReady) else $error("single-cycle op did not finish in one cycle");
  twoCycle_a: assert property (tk && op >= `ITD_OP_XFER_DW && op <= `ITD_OP_TBL_WTL
    |=> (cycleCount == 3'h2 && insertNop) ##1 decodeReady)
    else $error("two-cycle op length wrong");
  flowNop_a: assert property (tk && op == `ITD_OP_BRANCH |=> !decodeReady && insertNop
    ##1 decodeReady && !insertNop) else $error("flow change filler wrong");
  skipTwo_a: assert property (tk && op == `ITD_OP_SKIP && skipTaken && nextIsTwoWord
    |=> insertNop [*2] ##1 decodeReady) else $error("skip over two words not three cycles");
  retLong_a: assert property (tk && op >= `ITD_OP_RETURN && op <= `ITD_OP_RET_LIT
    && !exceptionPending |=> (cycleCount == 3'h3 && !decodeReady) [*2] ##1 decodeReady)
    else $error("return without exception not three cycles");
  retShort_a: assert property (tk && op >= `ITD_OP_RETURN && op <= `ITD_OP_RET_LIT
    && exceptionPending |=> cycleCount == 3'h2 ##1 decodeReady)
    else $error("return with exception not two cycles");
  twoWord_a: assert property (tk && w2 |=> wordCount == 2'h2 && fetchSecondWord)
    else $error("two-word op not flagged");
  oneWord_a: assert property (tk && !w2 |=> wordCount == 2'h1 && !fetchSecondWord)
    else $error("one-word op flagged as two-word");
  capture_a: assert property (tk |=> opClass == $past(op)
    && bitPositionFieldOut == $past(instrWord[15:12]))
    else $error("class or bit position not captured");
  byteLit_a: assert property (tk && instrWord[14]
    |=> tenBitLiteralOut == {2'h0, $past(instrWord[11:4])})
    else $error("byte literal not limited to 255");
  holdOut_a: assert property (!(instrValid && decodeReady)
    |=> $stable(opClass) && $stable(cycleCount))
    else $error("outputs changed without a taken instruction");
  divStep_a: assert property (tk && op >= `ITD_OP_DIV_S && op <= `ITD_OP_DIV_F
    |=> isDivideStep && cycleCount == 3'h1) else $error("divide step not single cycle");

  cover property (tk && op == `ITD_OP_CALL);
  cover property (tk && op == `ITD_OP_RETURN && exceptionPending);
  cover property (tk && op == `ITD_OP_SKIP && skipTaken && nextIsTwoWord);
  cover property (tk && op == `ITD_OP_DIV_U && repeatActive && interruptReq);
endmodule

bind itd_instruction_timing_decoder itd_decoder_chk u_chk (
  .clk, .nrst, .instrValid, .instrWord, .skipTaken, .nextIsTwoWord, .exceptionPending,
  .psvAccess, .repeatActive, .interruptReq, .decodeReady, .fetchSecondWord, .insertNop,
  .opClass, .wordCount, .cycleCount, .isDivideStep, .tenBitLiteralOut, .bitPositionFieldOut
);

// [testbench/itd_fetch_model.sv]
`timescale 1ns/1ps

module itd_fetch_model (
  // Clock.
  input  wire logic        clk,
  // Decoder handshake.
  input  wire logic        decodeReady,
  output logic             instrValid,
  output logic [23:0]      instrWord
);
  initial begin
    instrValid = 1'b0;
    instrWord  = 24'h000000;
  end

  // Presents a word at a falling edge and holds it until taken; the second word of a
  // two-word instruction is never presented and is not fetched by this model.
  task automatic send(input logic [23:0] w, input bit hold, output bit ok);
    ok = 1'b0;
    instrValid = 1'b1;
    instrWord = w;
    for (int n = 0; n < 8 && !ok; n++) begin
      #1 ok = decodeReady;
      @(negedge clk);
    end
    if (!hold) begin
      instrValid = 1'b0;
      instrWord = ~w;
    end
  endtask
endmodule

// [testbench/itd_instruction_timing_decoder_tb_top.sv]
`timescale 1ns/1ps
`include "itd_defines.vh"

module itd_instruction_timing_decoder_tb_top;
  // Clock, reset and qualifiers.
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        skipTaken = 1'b0, nextIsTwoWord = 1'b0, exceptionPending = 1'b0;
  logic        psvAccess = 1'b0, repeatActive = 1'b0, interruptReq = 1'b0;
  logic [1:0]  psvExtraCycles = 2'h0;
  // Fetch model and decoder outputs.
  wire         instrValid, decodeReady, fetchSecondWord, insertNop, opKnown, isDivideStep;
  wire         divideInterruptible, srcIndirect, destIndirect, mulSquare, accSelect;
  wire         accumulatorWriteBack;
  wire  [23:0] instrWord;
  wire  [3:0]  funcGroup, destWorkRegister, srcWorkRegister, divideRegisterPair, divisorRegister;
  wire  [3:0]  xPrefetchSource, yPrefetchSource, bitPositionFieldOut;
  wire  [1:0]  wordCount, xPrefetchDest, yPrefetchDest;
  wire  [5:0]  opClass;
  wire  [2:0]  cycleCount;
  wire  [4:0]  divideStepIndex, lit5Out;
  wire  [9:0]  tenBitLiteralOut;
  wire  [15:0] signedTenBitLiteralOut, lit16Out, slit4Out;
  wire  [22:0] lit23Out;
  int          miscompares = 0, nCompared = 0;
  // Group and cycle count of each operation class, class 00 in the top nibble.
  localparam logic [135:0] GRP = 136'h0000001111111111123456666666777896;
  localparam logic [135:0] CYC = 136'h1222221111111111111112222333221111;

  always #25 clk = ~clk;

  itd_fetch_model u_fetch (.clk, .decodeReady, .instrValid, .instrWord);

  itd_instruction_timing_decoder i_dut (
    .clk, .nrst, .instrValid, .instrWord, .skipTaken, .nextIsTwoWord, .exceptionPending,
    .psvAccess, .psvExtraCycles, .repeatActive, .interruptReq, .decodeReady, .fetchSecondWord,
    .insertNop, .funcGroup, .opClass, .opKnown, .wordCount, .cycleCount, .isDivideStep,
    .divideInterruptible, .divideStepIndex, .destWorkRegister, .srcWorkRegister, .srcIndirect,
    .destIndirect, .divideRegisterPair, .divisorRegister, .mulSquare, .accSelect,
    .accumulatorWriteBack, .xPrefetchSource, .yPrefetchSource, .xPrefetchDest, .yPrefetchDest,
    .tenBitLiteralOut, .signedTenBitLiteralOut, .lit16Out, .lit23Out, .lit5Out, .slit4Out,
    .bitPositionFieldOut);

  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic issue(input logic [23:0] w, input bit hold);
    bit ok;
    u_fetch.send(w, hold, ok);
    if (!ok) begin
      miscompares++;
      results();
    end
  endtask

  // Checks the filler cycles of a taken instruction of n cycles, then lets one clock pass.
  task automatic span(input int n);
    for (int i = 1; i < n; i++) begin
      chk("filler", 2'h1, {decodeReady, insertNop});
      @(negedge clk);
    end
    chk("ready", 2'h2, {decodeReady, insertNop});
    @(negedge clk);
  endtask

  task automatic tReset();
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset", 12'h9E0, {decodeReady, insertNop, fetchSecondWord, funcGroup,
        cycleCount, wordCount});
    nrst = 1'b1;
    @(negedge clk);
    $display("test reset done");
  endtask

  task automatic tTable();
    logic [5:0] op;
    logic [3:0] g;
    logic [3:0] c;
    logic [1:0] w;
    for (int i = 0; i < 34; i++) begin
      op = i[5:0];
      g = GRP[135-4*i -: 4];
      c = CYC[135-4*i -: 4];
      w = (op >= `ITD_OP_CALL && op <= `ITD_OP_LOOP) ? 2'h2 : 2'h1;
      issue({op, 18'h2AAAA}, 1'b0);
      chk("class", {g, op, 1'b1, w, c[2:0], w[1]},
          {funcGroup, opClass, opKnown, wordCount, cycleCount, fetchSecondWord});
      span(c);
    end
    issue(24'hFC0000, 1'b0);
    chk("unknown", 5'h1E, {funcGroup, opKnown});
    span(1);
    $display("test table done");
  endtask

  task automatic tSkip();
    for (int i = 0; i < 3; i++) begin
      skipTaken = i > 0;
      nextIsTwoWord = i > 1;
      issue({`ITD_OP_SKIP, 18'h00000}, 1'b0);
      chk("skip", i + 1, cycleCount);
      span(i + 1);
    end
    skipTaken = 1'b0;
    nextIsTwoWord = 1'b0;
    $display("test skip done");
  endtask

  task automatic tReturn();
    exceptionPending = 1'b1;
    for (int i = 0; i < 3; i++) begin
      issue({`ITD_OP_RETURN + i[5:0], 18'h00000}, 1'b0);
      chk("return", 3'h2, cycleCount);
      span(2);
    end
    exceptionPending = 1'b0;
    psvAccess = 1'b1;
    psvExtraCycles = 2'h2;
    issue({`ITD_OP_TBL_RDH, 18'h00000}, 1'b0);
    chk("psv", 3'h4, cycleCount);
    span(4);
    psvAccess = 1'b0;
    psvExtraCycles = 2'h0;
    $display("test return done");
  endtask

  task automatic tFields();
    logic [23:0] w;
    logic [23:0] tbl [4] = '{24'h003FF0, 24'h007FF0, 24'h002080, 24'h7FFFFF};
    for (int i = 0; i < 4; i++) begin
      w = tbl[i];
      issue(w, 1'b0);
      chk("fields",
          {w[14] ? {2'h0, w[11:4]} : w[13:4], {{6{w[13]}}, w[13:4]}, w[15:0],
          w[22:0], w[8:4], {{12{w[7]}}, w[7:4]}, w[15:12]}, {tenBitLiteralOut,
          signedTenBitLiteralOut, lit16Out, lit23Out, lit5Out, slit4Out, bitPositionFieldOut});
      span(1);
    end
    $display("test fields done");
  endtask

  task automatic tOperands();
    issue(24'h81B6E0, 1'b0);
    chk("dsp", 14'h3B6E, {accSelect, accumulatorWriteBack, xPrefetchSource,
        yPrefetchSource, xPrefetchDest, yPrefetchDest});
    span(1);
    issue(24'h340289, 1'b0);
    chk("divpair", 8'h59, {divideRegisterPair, divisorRegister});
    span(1);
    issue(24'h420183, 1'b0);
    chk("square", 9'h133, {mulSquare, destWorkRegister, srcWorkRegister});
    span(1);
    issue(24'h400985, 1'b0);
    chk("mulpair", 11'h135, {mulSquare, srcIndirect, destIndirect,
        destWorkRegister, srcWorkRegister});
    span(1);
    issue(24'h000985, 1'b0);
    chk("indirect", 2'h3, {srcIndirect, destIndirect});
    span(1);
    $display("test operands done");
  endtask

  task automatic tDivide();
    issue({`ITD_OP_REPEAT, 18'h00000}, 1'b1);
    chk("repeat", 3'h1, cycleCount);
    repeatActive = 1'b1;
    for (int i = 0; i < `ITD_DIV_REPEATS; i++) begin
      interruptReq = i == 5;
      issue({`ITD_OP_DIV_U, 18'h00289}, i < `ITD_DIV_REPEATS - 1);
      chk("divstep", {1'b1, i == 5, i[4:0], 3'h1, 1'b1}, {isDivideStep,
          divideInterruptible, divideStepIndex, cycleCount, decodeReady});
    end
    repeatActive = 1'b0;
    interruptReq = 1'b0;
    $display("test divide done");
  endtask

  initial begin
    tReset();
    tTable();
    tSkip();
    tReset();
    tReturn();
    tFields();
    tOperands();
    tDivide();
    results();
  end
endmodule
